// ==== shared/ipr_pkg.sv ====
// constants and carrier types for the interrupt line 0..11 priority registers
// assumes a single system clock domain shared by bus master and block
package ipr_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int LINES = 12;
    localparam int REGS = 3;
    localparam int LINES_PER_REG = 4;
    localparam int SLOT_W = 8;
    localparam int LEVEL_W = 2;
    localparam int LEVEL_LSB = 6;
    localparam int LINE_W = 4;
    localparam logic [ADDR_W-1:0] IRQ0_3_PRIORITY_OFFS = 12'h300;
    localparam logic [ADDR_W-1:0] IRQ4_7_PRIORITY_OFFS = 12'h304;
    localparam logic [ADDR_W-1:0] IRQ8_11_PRIORITY_OFFS = 12'h308;
    localparam logic [REGS-1:0][ADDR_W-1:0] REG_OFFS =
        {IRQ8_11_PRIORITY_OFFS, IRQ4_7_PRIORITY_OFFS, IRQ0_3_PRIORITY_OFFS};
    localparam logic [DATA_W-1:0] LEVEL_MASK = 32'hc0c0c0c0;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 2'h0;
    localparam logic [LEVEL_W-1:0] LEVEL_LEAST = 2'h3;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h00000000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ipr_req_type;

    typedef logic [LINES-1:0][LEVEL_W-1:0] ipr_levels_type;
endpackage

// ==== rtl/ipr_priority_regs.sv ====
// priority level registers for interrupt lines 0..11, plus a small
// arbiter that names the most urgent requesting line
// assumes bus request and line requests are synchronous to i_sys_clk
//
// Functional notes
// - eight-bit slot per line, top two bits stored
// - level zero most urgent, three least urgent
// - first register holds lines 0 to 3
// - second register holds lines 4 to 7
// - third register holds lines 8 to 11
// - unimplemented bits read zero, writes ignored
// - registers at 0x300/0x304/0x308, reset zero
`timescale 1ns/100ps
module ipr_priority_regs (
    input wire logic i_sys_clk, // system clock, 25 MHz
    input wire logic i_nrst, // asynchronous reset, active low
    input wire ipr_pkg::ipr_req_type i_bus, // register access request
    input wire logic [ipr_pkg::LINES-1:0] i_req, // pending enabled lines
    output logic [ipr_pkg::DATA_W-1:0] o_rdata, // read data, next cycle
    output ipr_pkg::ipr_levels_type o_levels, // stored level per line
    output logic o_top_valid, // some line requesting
    output logic [ipr_pkg::LINE_W-1:0] o_top_line // most urgent line
);
    ipr_pkg::ipr_levels_type levels_q, levels_d;
    logic [ipr_pkg::DATA_W-1:0] rdata_q, rdata_d;
    logic top_valid_q, top_valid_d;
    logic [ipr_pkg::LINE_W-1:0] top_line_q, top_line_d;
    logic [ipr_pkg::LEVEL_W-1:0] best_lvl;
    logic [ipr_pkg::REGS-1:0][ipr_pkg::DATA_W-1:0] image;
    logic bus_hit;

    // bus view of each register: level in the top two bits of its slot
    always_comb
    begin
        image = '0;
        for (int k = 0; k < ipr_pkg::LINES_PER_REG; k++)
        begin
            image[0][k*ipr_pkg::SLOT_W+ipr_pkg::LEVEL_LSB
                +: ipr_pkg::LEVEL_W] = levels_q[k];
            image[1][k*ipr_pkg::SLOT_W+ipr_pkg::LEVEL_LSB
                +: ipr_pkg::LEVEL_W] =
                levels_q[ipr_pkg::LINES_PER_REG+k];
            image[2][k*ipr_pkg::SLOT_W+ipr_pkg::LEVEL_LSB
                +: ipr_pkg::LEVEL_W] =
                levels_q[2*ipr_pkg::LINES_PER_REG+k];
        end
    end

    always_comb
    begin
        levels_d = levels_q;
        rdata_d = ipr_pkg::RDATA_RESET;
        bus_hit = 1'b0;
        for (int r = 0; r < ipr_pkg::REGS; r++)
        begin
            if (i_bus.addr == ipr_pkg::REG_OFFS[r])
            begin
                bus_hit = 1'b1;
                // a read sees the levels from before a same-cycle write
                if (i_bus.rd)
                begin
                    rdata_d = image[r];
                end
                if (i_bus.wr)
                begin
                    for (int k = 0; k < ipr_pkg::LINES_PER_REG; k++)
                    begin
                        // only the top two bits of each slot are kept
                        levels_d[r*ipr_pkg::LINES_PER_REG+k] =
                            i_bus.wdata[k*ipr_pkg::SLOT_W
                            +ipr_pkg::LEVEL_LSB +: ipr_pkg::LEVEL_W];
                    end
                end
            end
        end
    end

    // lowest level value wins, lowest line number breaks a tie
    always_comb
    begin
        top_valid_d = 1'b0;
        top_line_d = '0;
        best_lvl = ipr_pkg::LEVEL_LEAST;
        for (int i = 0; i < ipr_pkg::LINES; i++)
        begin
            if (i_req[i] && (!top_valid_d || levels_q[i] < best_lvl))
            begin
                top_valid_d = 1'b1;
                top_line_d = ipr_pkg::LINE_W'(i);
                best_lvl = levels_q[i];
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            levels_q <= {ipr_pkg::LINES{ipr_pkg::LEVEL_RESET}};
            rdata_q <= ipr_pkg::RDATA_RESET;
            top_valid_q <= 1'b0;
            top_line_q <= '0;
        end
        else
        begin
            levels_q <= levels_d;
            rdata_q <= rdata_d;
            top_valid_q <= top_valid_d;
            top_line_q <= top_line_d;
        end
    end

    assign o_levels = levels_q;
    assign o_rdata = rdata_q;
    assign o_top_valid = top_valid_q;
    assign o_top_line = top_line_q;

    // helper: is there a requesting line strictly more urgent than the winner
    logic beaten;
    always_comb
    begin
        beaten = 1'b0;
        for (int i = 0; i < ipr_pkg::LINES; i++)
        begin
            if (i_req[i] && levels_q[i] < levels_q[top_line_d])
            begin
                beaten = 1'b1;
            end
        end
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);

    sequence s_wr(logic [ipr_pkg::ADDR_W-1:0] a);
        i_bus.wr && i_bus.addr == a;
    endsequence

    sequence s_rd(logic [ipr_pkg::ADDR_W-1:0] a);
        i_bus.rd && !i_bus.wr && i_bus.addr == a;
    endsequence

    first_reg_map_a: assert property (
        s_wr(12'h300) |=> levels_q[3] == $past(i_bus.wdata[31:30])
            && levels_q[2] == $past(i_bus.wdata[23:22])
            && levels_q[1] == $past(i_bus.wdata[15:14])
            && levels_q[0] == $past(i_bus.wdata[7:6]))
        else $error("first register fields misplaced");

    second_reg_map_a: assert property (
        s_wr(12'h304) |=> levels_q[7] == $past(i_bus.wdata[31:30])
            && levels_q[4] == $past(i_bus.wdata[7:6]))
        else $error("second register fields misplaced");

    third_reg_map_a: assert property (
        s_wr(12'h308) |=> levels_q[11] == $past(i_bus.wdata[31:30])
            && levels_q[8] == $past(i_bus.wdata[7:6]))
        else $error("third register fields misplaced");

    slot_readback_a: assert property (
        (s_wr(12'h304) ##1 s_rd(12'h304)) |=>
            o_rdata == ($past(i_bus.wdata, 2) & ipr_pkg::LEVEL_MASK))
        else $error("readback does not keep two bits per slot");

    reserved_zero_a: assert property (
        (o_rdata & ~ipr_pkg::LEVEL_MASK) == 32'h00000000)
        else $error("reserved read data bits not zero");

    unmapped_read_a: assert property (
        i_bus.rd && i_bus.addr != 12'h300 && i_bus.addr != 12'h304
            && i_bus.addr != 12'h308 |=> o_rdata == 32'h00000000)
        else $error("unmapped offset read nonzero");

    read_value_a: assert property (
        s_rd(12'h308) |=> o_rdata[15:14] == $past(levels_q[9])
            && o_rdata[23:22] == $past(levels_q[10]))
        else $error("read does not return stored levels");

    urgent_wins_a: assert property (
        top_valid_d && !beaten |=> o_top_valid
            && o_top_line == $past(top_line_d))
        else $error("arbiter result not registered");

    no_better_a: assert property (
        (|i_req) |-> top_valid_d && !beaten)
        else $error("a more urgent requesting line was passed over");

    sequence s_wr_rd(logic [ipr_pkg::ADDR_W-1:0] a);
        s_wr(a) ##1 s_rd(a);
    endsequence

    first_readback_a: assert property (
        s_wr_rd(ipr_pkg::IRQ0_3_PRIORITY_OFFS) |=>
            o_rdata == ($past(i_bus.wdata, 2) & ipr_pkg::LEVEL_MASK))
        else $error("first register readback not masked");

    third_readback_a: assert property (
        s_wr_rd(ipr_pkg::IRQ8_11_PRIORITY_OFFS) |=>
            o_rdata == ($past(i_bus.wdata, 2) & ipr_pkg::LEVEL_MASK))
        else $error("third register readback not masked");

    levels_hold_a: assert property (
        !(i_bus.wr && bus_hit) |=> levels_q == $past(levels_q))
        else $error("levels changed without a mapped write");

    rdata_idle_a: assert property (
        !(i_bus.rd && bus_hit) |=> o_rdata == ipr_pkg::RDATA_RESET)
        else $error("read data not zero without a mapped read");

    idle_no_top_a: assert property (
        !(|i_req) |=> !o_top_valid && o_top_line == '0)
        else $error("arbiter reports a line with no request");

    tie_low_line_a: assert property (
        i_req[0] && levels_q[0] == 2'h0 |=> o_top_line == 4'h0)
        else $error("tie not resolved toward the lowest line");

    top_line_range_a: assert property (
        o_top_valid |-> o_top_line < ipr_pkg::LINE_W'(ipr_pkg::LINES))
        else $error("arbiter names a line that does not exist");

    req_seen_a: assert property (
        (|i_req) |=> o_top_valid)
        else $error("a requesting line was not reported");
endmodule

// ==== verification/ipr_priority_regs_tb_top.sv ====
// self-checking bench for the line 0..11 priority registers
// assumes the design's strobe bus and one-cycle registered answers
`timescale 1ns/100ps
module ipr_priority_regs_tb_top;
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    ipr_pkg::ipr_req_type i_bus = '0;
    logic [ipr_pkg::LINES-1:0] i_req = '0;
    logic [ipr_pkg::DATA_W-1:0] o_rdata;
    ipr_pkg::ipr_levels_type o_levels;
    ipr_pkg::ipr_levels_type exp_lv = '0;
    logic o_top_valid;
    logic [ipr_pkg::LINE_W-1:0] o_top_line;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;

    always #20 i_sys_clk = ~i_sys_clk;

    ipr_priority_regs i_ipr_priority_regs (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_bus(i_bus),
        .i_req(i_req),
        .o_rdata(o_rdata),
        .o_levels(o_levels),
        .o_top_valid(o_top_valid),
        .o_top_line(o_top_line)
    );

    task automatic finish_test;
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge i_sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            err_count++;
            finish_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (e !== g)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one bus cycle; read data expected from the levels before the write
    task automatic acc(input logic w, r, input logic [11:0] a,
                       input logic [31:0] d);
        logic [31:0] e;
        e = '0;
        for (int n = 0; n < 3; n++)
            for (int k = 0; k < 4; k++)
                if (a == ipr_pkg::REG_OFFS[n])
                    e[8*k+7 -: 2] = exp_lv[4*n+k];
        @(posedge i_sys_clk);
        i_bus <= '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge i_sys_clk);
        i_bus <= '0;
        #1;
        for (int n = 0; n < 3; n++)
            for (int k = 0; k < 4; k++)
                if (w && a == ipr_pkg::REG_OFFS[n])
                    exp_lv[4*n+k] = d[8*k+7 -: 2];
        chk("levels", {8'h00, exp_lv}, {8'h00, o_levels});
        if (r)
            chk("rdata", e, o_rdata);
    endtask

    task automatic arb(input logic [11:0] q, input logic v,
                       input logic [3:0] ln);
        @(posedge i_sys_clk);
        i_req <= q;
        @(posedge i_sys_clk);
        i_req <= '0;
        #1;
        chk("top_valid", {31'h0, v}, {31'h0, o_top_valid});
        chk("top_line", {28'h0, ln}, {28'h0, o_top_line});
    endtask

    task automatic t_reset;
        for (int n = 0; n < 3; n++)
            acc(1'b0, 1'b1, ipr_pkg::REG_OFFS[n], 32'h0);
    endtask

    task automatic t_fields;
        for (int n = 0; n < 3; n++)
        begin
            acc(1'b1, 1'b0, ipr_pkg::REG_OFFS[n], 32'hffffffff);
            acc(1'b0, 1'b1, ipr_pkg::REG_OFFS[n], 32'h0);
            acc(1'b1, 1'b1, ipr_pkg::REG_OFFS[n], 32'h3fbf7fff);
            acc(1'b0, 1'b1, ipr_pkg::REG_OFFS[n], 32'h0);
        end
    endtask

    task automatic t_unmapped;
        acc(1'b1, 1'b0, 12'h30c, 32'hffffffff);
        acc(1'b0, 1'b1, 12'h30c, 32'h0);
        acc(1'b1, 1'b1, 12'h2fc, 32'hffffffff);
    endtask

    task automatic t_arb;
        arb(12'hfff, 1'b1, 4'h3);
        arb(12'h777, 1'b1, 4'h1);
        arb(12'h555, 1'b1, 4'h2);
        arb(12'h880, 1'b1, 4'h7);
        arb(12'h000, 1'b0, 4'h0);
        acc(1'b1, 1'b0, ipr_pkg::REG_OFFS[2], 32'h0);
        arb(12'h120, 1'b1, 4'h8);
    endtask

    // write then read the same register on the very next edge
    task automatic b2b(input int n, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_bus <= '{wr: 1'b1, rd: 1'b0, addr: ipr_pkg::REG_OFFS[n], wdata: d};
        @(posedge i_sys_clk);
        i_bus <= '{wr: 1'b0, rd: 1'b1, addr: ipr_pkg::REG_OFFS[n], wdata: '0};
        @(posedge i_sys_clk);
        i_bus <= '0;
        #1;
        chk("rdata", d & ipr_pkg::LEVEL_MASK, o_rdata);
        @(posedge i_sys_clk);
        #1;
        chk("rdata_idle", 32'h0, o_rdata);
        for (int k = 0; k < 4; k++)
            exp_lv[4*n+k] = d[8*k+7 -: 2];
        chk("levels", {8'h00, exp_lv}, {8'h00, o_levels});
    endtask

    task automatic t_b2b;
        b2b(0, 32'hffffffff);
        b2b(1, 32'h80c04000);
        b2b(2, 32'h40800000);
    endtask

    // reset in mid-run must clear levels that were written
    task automatic t_midreset;
        @(posedge i_sys_clk);
        i_nrst <= 1'b0;
        #1;
        exp_lv = '0;
        chk("levels_rst", {8'h00, exp_lv}, {8'h00, o_levels});
        chk("rdata_rst", 32'h0, o_rdata);
        @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        for (int n = 0; n < 3; n++)
            acc(1'b0, 1'b1, ipr_pkg::REG_OFFS[n], 32'h0);
        arb(12'h801, 1'b1, 4'h0);
    endtask

    initial
    begin
        repeat (2) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        t_reset();
        t_fields();
        t_unmapped();
        t_arb();
        t_b2b();
        t_midreset();
        finish_test();
    end
endmodule
